// ==== bench/table_write_xor_test_exec_tb_top.sv ====
// ==========
// bench for the execution block
module table_write_xor_test_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, srst = 1'b1, instr_valid = 1'b0, next_is_two_word = 1'b0;
    logic extended_set_enable_bit = 1'b1, table_pointer_we = 1'b0, m_n = 1'b0, m_z = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0] table_latch = 8'h00, reg_rdata = 8'h00, m_acc = 8'h00;
    logic [3:0] bank_select_reg = 4'h0;
    logic [11:0] third_indirect_pointer = 12'h000, reg_addr;
    logic [20:0] table_pointer_wdata = 21'h000000, table_pointer, p, np;
    logic [2:0] hold_rd_addr = 3'h0;
    logic [7:0] hold_rd_data, acc, reg_wdata, res, k;
    logic table_byte_high, flag_n, flag_z, reg_we, reg_indexed, discard_fetch, busy, a;
    logic fsr_adjust_we, fsr_adjust_sub, return_req, ext_enabled, clk_en = 1'b1;
    logic [1:0] fsr_adjust_sel, m;
    logic [5:0] fsr_adjust_k;
    logic [8:0] fsr_cap = 9'h000;
    int seed = 32'h60441bb6, err_total = 0, n_tests = 0, n_disc = 0, n_rwe = 0, n_ret = 0;
    int d0, w0, r0;

    always #10 ref_clk = ~ref_clk;

    // design under test; clock enable is dropped once near the end
    twx_exec i_dut (
        .ref_clk, .srst, .clk_en, .instr_valid, .instr_word, .next_is_two_word,
        .extended_set_enable_bit, .table_latch, .reg_rdata, .bank_select_reg,
        .third_indirect_pointer, .table_pointer_wdata, .table_pointer_we, .hold_rd_addr,
        .table_pointer, .hold_rd_data, .table_byte_high, .acc, .flag_n, .flag_z, .reg_we,
        .reg_addr, .reg_wdata, .reg_indexed, .discard_fetch, .busy, .fsr_adjust_we,
        .fsr_adjust_sel, .fsr_adjust_sub, .fsr_adjust_k, .return_req, .ext_enabled
    );

    // pulse counters, so one-cycle strobes are never missed by late sampling
    always @(posedge ref_clk)
    begin
        n_disc <= n_disc + int'(discard_fetch);
        n_rwe <= n_rwe + int'(reg_we);
        n_ret <= n_ret + int'(return_req);
        if (fsr_adjust_we)
            fsr_cap <= {fsr_adjust_sub, fsr_adjust_sel, fsr_adjust_k};
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one request pulse, then enough idle cycles for the longest operation
    task automatic op(input logic [15:0] w);
        d0 = n_disc;
        w0 = n_rwe;
        r0 = n_ret;
        @(posedge ref_clk);
        instr_word <= w;
        instr_valid <= 1'b1;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    task automatic loadp(input logic [20:0] v);
        @(posedge ref_clk);
        table_pointer_wdata <= v;
        table_pointer_we <= 1'b1;
        table_latch <= 8'($random(seed));
        @(posedge ref_clk);
        table_pointer_we <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    function automatic logic [20:0] step(input logic [20:0] v, input logic [1:0] md);
        return v + {{20{md == 2'h2}}, md != 2'h0};
    endfunction

    // short addresses index the third pointer when extended and low, else map to the access bank low half or the top page
    function automatic logic [11:0] ea(input logic sel, input logic [7:0] f);
        if (sel)
            return {bank_select_reg, f};
        if (extended_set_enable_bit && f <= 8'h5f)
            return third_indirect_pointer + 12'(f);
        return {(f >= 8'h80) ? 4'hf : 4'h0, f};
    endfunction

    initial
    begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(ext_enabled, 1'b1);
        // table writes: pointer wrap corners first, all four modes
        for (int i = 0; i < 12; i++)
        begin
            p = (i == 0) ? 21'h1fffff : (i == 1) ? 21'h000000 : 21'($random(seed));
            m = 2'(i + 1);
            loadp(p);
            op({14'h0003, m});
            np = step(p, m);
            chk(table_pointer, np);
            chk(table_byte_high, np[0]);
            chk({flag_n, flag_z}, {m_n, m_z});
            @(posedge ref_clk);
            hold_rd_addr <= (m == 2'h3) ? np[2:0] : p[2:0];
            repeat (2) @(posedge ref_clk);
            #1;
            chk(hold_rd_data, table_latch);
        end
        // pointer adjust forms, pointer field 3 meaning the return variant
        for (int j = 0; j < 8; j++)
        begin
            k = 8'($random(seed));
            op({7'h74, j[2], j[1:0], k[5:0]});
            chk(n_ret - r0, j[1:0] == 2'h3);
            chk(fsr_cap, {j[2], (j[1:0] == 2'h3) ? 2'h2 : j[1:0], k[5:0]});
        end
        // push form shares the upper opcode bits but is no pointer adjust
        p = 21'(fsr_cap);
        op(16'hea3f);
        chk(fsr_cap, p[8:0]);
        chk(n_ret - r0, 0);
        // xor and test-skip mix; extended set switched off halfway
        for (int i = 0; i < 40; i++)
        begin
            if (i == 20)
            begin
                @(posedge ref_clk);
                extended_set_enable_bit <= 1'b0;
                repeat (6) @(posedge ref_clk);
                #1;
                chk(ext_enabled, 1'b0);
            end
            k = (i == 0) ? m_acc : 8'($random(seed));
            m = 2'(i);
            a = 1'($random(seed));
            @(posedge ref_clk);
            reg_rdata <= (i % 8 == 3) ? 8'h00 : 8'($random(seed));
            next_is_two_word <= i[3];
            bank_select_reg <= 4'($random(seed));
            third_indirect_pointer <= 12'($random(seed));
            op((m == 0) ? {8'h0a, k} : (m == 3) ? {7'h33, a, k} : {6'h06, m[1], a, k});
            res = m_acc ^ ((m == 0) ? k : reg_rdata);
            if (m != 3)
            begin
                m_n = res[7];
                m_z = (res == 8'h00);
            end
            if (m < 2)
                m_acc = res;
            chk(acc, m_acc);
            chk({flag_n, flag_z}, {m_n, m_z});
            if (m != 0)
            begin
                chk(reg_addr, ea(a, k));
                chk(reg_indexed, !a && extended_set_enable_bit && k <= 8'h5f);
            end
            if (m == 2)
                chk(reg_wdata, res);
            chk(n_rwe - w0, m == 2);
            chk(n_disc - d0, (m == 3 && reg_rdata == 0) ? 1 + next_is_two_word : 0);
        end
        // extended set now off: the return form must do nothing
        op({7'h74, 1'b0, 2'h3, 6'h01});
        chk(n_ret - r0, 0);
        // frozen clock enable: a request must leave no trace
        @(posedge ref_clk);
        clk_en <= 1'b0;
        op({8'h0a, 8'hff});
        chk(acc, m_acc);
        chk(n_rwe - w0, 0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(acc, m_acc);
        end_of_test();
    end
endmodule

// ==== bench/twx_exec_asserts.sv ====
// ==========
// checker on the execution block ports
module twx_exec_asserts #(
    parameter int ptr_w = 21
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic next_is_two_word,
    input wire logic [7:0] reg_rdata,
    input wire logic [ptr_w-1:0] table_pointer,
    input wire logic [7:0] acc,
    input wire logic flag_n,
    input wire logic flag_z,
    input wire logic reg_we,
    input wire logic [7:0] reg_wdata,
    input wire logic discard_fetch,
    input wire logic busy,
    input wire logic fsr_adjust_we,
    input wire logic [1:0] fsr_adjust_sel,
    input wire logic return_req,
    input wire logic ext_enabled
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    // accepted requests; busy lags acceptance, so it only hides later requests
    wire take = instr_valid && clk_en && !busy;
    wire is_xl = take && instr_word[15:8] == twx_pkg::xor_lit_hi;
    wire is_xw = take && instr_word[15:10] == twx_pkg::xor_reg_hi;
    wire is_ts = take && instr_word[15:9] == twx_pkg::test_skip_hi;
    wire is_tw = take && instr_word[15:2] == twx_pkg::tbl_wr_hi;
    wire is_zs = is_ts && reg_rdata == 8'h00;
    wire is_rt = take && ext_enabled && instr_word[15:9] == 7'h74 && instr_word[7:6] == 2'h3;
    logic [7:0] x_q;
    logic [ptr_w-1:0] p_q;
    // expected xor result and pointer step, captured when the request is accepted
    always_ff @(posedge ref_clk)
    begin
        x_q <= acc ^ (is_xl ? instr_word[7:0] : reg_rdata);
        if (is_tw)
            p_q <= table_pointer
                + {{(ptr_w-1){instr_word[1:0] == 2'h2}}, instr_word[1:0] != 2'h0};
    end
    a_xor_lit_acc: assert property (
        is_xl |=> acc == x_q && flag_z == (x_q == 8'h00) && flag_n == x_q[7])
        else $error("xor literal result wrong");
    a_xor_reg_dest: assert property (
        is_xw && instr_word[9] |=> reg_we && reg_wdata == x_q && acc == $past(acc))
        else $error("xor register write-back wrong");
    a_table_write_len: assert property (
        is_tw |=> busy && $stable(flag_z) && $stable(flag_n) ##1 !busy)
        else $error("table write length wrong");
    a_table_ptr_step: assert property (
        is_tw |-> ##[2:3] table_pointer == p_q)
        else $error("table pointer step wrong");
    a_skip_one_slot: assert property (
        is_zs && !next_is_two_word |=> discard_fetch ##1 !discard_fetch)
        else $error("single skip wrong");
    a_skip_two_slots: assert property (
        is_zs && next_is_two_word |=> discard_fetch [*2] ##1 !discard_fetch)
        else $error("double skip wrong");
    a_skip_keeps_flags: assert property (
        is_ts |=> ($stable(flag_n) && $stable(flag_z) && !reg_we) [*3])
        else $error("test skip touched flags");
    a_ret_form_pulse: assert property (
        is_rt |=> return_req && fsr_adjust_we && fsr_adjust_sel == 2'h2 ##1 !return_req)
        else $error("return form wrong");
endmodule

bind twx_exec twx_exec_asserts #(.ptr_w(ptr_w)) i_chk (
    .ref_clk, .srst, .clk_en, .instr_valid, .instr_word, .next_is_two_word, .reg_rdata,
    .table_pointer, .acc, .flag_n, .flag_z, .reg_we, .reg_wdata, .discard_fetch, .busy,
    .fsr_adjust_we, .fsr_adjust_sel, .return_req, .ext_enabled
);

// ==== hdl/twx_exec.sv ====
// Operation
// - table write mode 0 keeps the pointer, 1 post-increments, 2 post-decrements, 3 pre-increments.
// - the low three pointer bits pick which of eight holding registers takes the latch byte.
// - the table pointer is a 21-bit byte address over a 2-Mbyte range.
// - pointer bit zero picks the low byte (0) or high byte (1) of a program word.
// - test-and-skip checks the register for zero and, if so, turns the next instruction into a no-op.
// - a skip over a two-word instruction makes the test-and-skip three cycles long.
// - access bit clear selects the access bank, set uses the bank select register.
// - with access bit clear and extended set on, addresses up to 95 are indexed offsets.
// - xor-literal xors an 8-bit literal into the accumulator in one cycle, setting n and z.
// - xor-register xors into accumulator (d=0) or register (d=1), setting n and z.
// - the extended set adds eight literal instructions and indexed literal offset addressing.
// - extended features are on when unprogrammed; the configuration bit enables or disables them.
// - the pointer add and subtract literal forms on the third pointer also return.
module twx_exec #(
    parameter int ptr_w = 21,
    parameter int holds = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic next_is_two_word,
    input wire logic extended_set_enable_bit,
    input wire logic [7:0] table_latch,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] bank_select_reg,
    input wire logic [11:0] third_indirect_pointer,
    input wire logic [ptr_w-1:0] table_pointer_wdata,
    input wire logic table_pointer_we,
    input wire logic [2:0] hold_rd_addr,
    output logic [ptr_w-1:0] table_pointer,
    output logic [7:0] hold_rd_data,
    output logic table_byte_high,
    output logic [7:0] acc,
    output logic flag_n,
    output logic flag_z,
    output logic reg_we,
    output logic [11:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_indexed,
    output logic discard_fetch,
    output logic busy,
    output logic fsr_adjust_we,
    output logic [1:0] fsr_adjust_sel,
    output logic fsr_adjust_sub,
    output logic [5:0] fsr_adjust_k,
    output logic return_req,
    output logic ext_enabled
);
    twx_pkg::twx_state_type state_q;
    twx_pkg::twx_state_type state_d;
    logic [1:0] skip_left_q;
    logic [1:0] tw_mode_q;
    logic [ptr_w-1:0] ptr_q;
    logic ext_sync;

    // ==========================================
    // decode
    wire idle = (state_q == twx_pkg::twx_idle);
    wire go = clk_en && idle && instr_valid;
    wire [1:0] tw_mode = instr_word[1:0];
    wire is_tw = (instr_word[15:2] == twx_pkg::tbl_wr_hi);
    wire is_tst = (instr_word[15:9] == twx_pkg::test_skip_hi);
    wire is_xl_op = (instr_word[15:8] == twx_pkg::xor_lit_hi);
    wire is_xr_op = (instr_word[15:10] == twx_pkg::xor_reg_hi);
    wire is_fsr_ops = ext_sync && (instr_word[15:9] == twx_pkg::ptr_adj_hi);
    wire is_sub = instr_word[8];
    wire [1:0] fsr_sel = instr_word[7:6];
    wire is_ret_form = is_fsr_ops && (fsr_sel == twx_pkg::fsr_return_sel);
    wire acc_bit = instr_word[8];
    wire dst_bit = instr_word[9];
    wire [7:0] f_addr = instr_word[7:0];

    // ==========================================
    // operand address: access bank, banked, or indexed from third pointer
    wire use_indexed = !acc_bit && ext_sync && (f_addr <= twx_pkg::indexed_limit);
    wire [11:0] idx_addr = third_indirect_pointer + {4'h0, f_addr};
    wire [11:0] access_addr = (f_addr[7]) ? {4'hf, f_addr} : {4'h0, f_addr};
    wire [11:0] bank_addr = {bank_select_reg, f_addr};
    wire [11:0] op_addr = use_indexed ? idx_addr : (acc_bit ? bank_addr : access_addr);

    // ==========================================
    // xor datapath
    wire [7:0] xl_res = acc ^ instr_word[7:0];
    wire [7:0] xr_res = acc ^ reg_rdata;
    wire tst_zero = (reg_rdata == 8'h00);

    // ==========================================
    // pointer arithmetic: pre-increment adjusts before the store address is taken
    wire [ptr_w-1:0] ptr_inc = ptr_q + ptr_w'(1);
    wire [ptr_w-1:0] ptr_dec = ptr_q - ptr_w'(1);
    wire [ptr_w-1:0] ptr_used = (tw_mode_q == twx_pkg::mode_pre_inc) ? ptr_inc : ptr_q;
    wire [ptr_w-1:0] ptr_after = (tw_mode_q == twx_pkg::mode_none) ? ptr_q :
        (tw_mode_q == twx_pkg::mode_post_dec) ? ptr_dec : ptr_inc;
    wire tw_write = clk_en && (state_q == twx_pkg::twx_tw2);

    // ==========================================
    // configuration bit passes the pin synchroniser
    twx_sync3 u_ext_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .din(extended_set_enable_bit),
        .dout(ext_sync)
    );

    // ==========================================
    // holding registers, indexed by low pointer bits
    twx_hold_mem #(
        .depth(holds),
        .aw(twx_pkg::hold_sel_width)
    ) u_hold (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .wr_en(tw_write),
        .wr_addr(ptr_used[2:0]),
        .wr_data(table_latch),
        .rd_addr(hold_rd_addr),
        .rd_data(hold_rd_data)
    );

    // ==========================================
    // sequencing of multi-cycle instructions
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            twx_pkg::twx_idle:
            begin
                if (instr_valid && is_tw)
                    state_d = twx_pkg::twx_tw2;
                else if (instr_valid && is_tst && tst_zero)
                    state_d = twx_pkg::twx_skip;
                else if (instr_valid && is_ret_form)
                    state_d = twx_pkg::twx_ret;
            end
            twx_pkg::twx_tw2:
                state_d = twx_pkg::twx_idle;
            twx_pkg::twx_skip:
            begin
                if (skip_left_q == twx_pkg::skip_one)
                    state_d = twx_pkg::twx_idle;
            end
            twx_pkg::twx_ret:
                state_d = twx_pkg::twx_idle;
            default:
                state_d = twx_pkg::twx_idle;
        endcase
    end

    // ==========================================
    // state and skip counter
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_q <= twx_pkg::twx_idle;
            skip_left_q <= 2'h0;
            tw_mode_q <= twx_pkg::mode_none;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            if (go)
            begin
                tw_mode_q <= tw_mode;
                skip_left_q <= next_is_two_word ? twx_pkg::skip_two : twx_pkg::skip_one;
            end
            else if (state_q == twx_pkg::twx_skip)
                skip_left_q <= skip_left_q - 2'h1;
        end
    end

    // ==========================================
    // table pointer; a software load is ignored while an instruction is in flight
    wire ptr_load = table_pointer_we && idle;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            ptr_q <= twx_pkg::ptr_reset;
        else if (clk_en)
        begin
            if (tw_write)
                ptr_q <= ptr_after;
            else if (ptr_load)
                ptr_q <= table_pointer_wdata;
        end
    end

    // ==========================================
    // result selection; only the two xor forms may touch n and z
    wire do_xl = go && is_xl_op;
    wire do_xr = go && is_xr_op;
    wire xr_to_reg = do_xr && dst_bit;
    wire acc_load = do_xl || (do_xr && !dst_bit);
    wire flag_load = do_xl || do_xr;
    wire [7:0] x_res = do_xl ? xl_res : xr_res;
    wire do_adj = go && is_fsr_ops;

    // ==========================================
    // accumulator and n/z flags
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            acc <= 8'h00;
            flag_n <= 1'b0;
            flag_z <= 1'b0;
        end
        else if (clk_en)
        begin
            if (acc_load)
                acc <= x_res;
            if (flag_load)
            begin
                flag_n <= x_res[7];
                flag_z <= (x_res == 8'h00);
            end
        end
    end

    // ==========================================
    // register file port; the address follows the operand field every cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            reg_we <= 1'b0;
            reg_addr <= 12'h000;
            reg_wdata <= 8'h00;
            reg_indexed <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_we <= xr_to_reg;
            reg_addr <= op_addr;
            reg_indexed <= use_indexed;
            if (xr_to_reg)
                reg_wdata <= xr_res;
        end
    end

    // ==========================================
    // pointer adjust and return strobes, one cycle each
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            fsr_adjust_we <= 1'b0;
            fsr_adjust_sel <= 2'h0;
            fsr_adjust_sub <= 1'b0;
            fsr_adjust_k <= 6'h00;
            return_req <= 1'b0;
        end
        else if (clk_en)
        begin
            fsr_adjust_we <= do_adj;
            return_req <= do_adj && is_ret_form;
            if (do_adj)
            begin
                fsr_adjust_sel <= is_ret_form ? 2'h2 : fsr_sel;
                fsr_adjust_sub <= is_sub;
                fsr_adjust_k <= instr_word[5:0];
            end
        end
    end

    // ==========================================
    // stall view; busy doubles as the stall for the fetch unit
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            discard_fetch <= 1'b0;
            busy <= 1'b0;
        end
        else if (clk_en)
        begin
            discard_fetch <= (state_d == twx_pkg::twx_skip);
            busy <= (state_d != twx_pkg::twx_idle);
        end
    end

    // ==========================================
    // pointer and configuration view, one cycle behind the live pointer
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            table_pointer <= twx_pkg::ptr_reset;
            table_byte_high <= 1'b0;
            ext_enabled <= 1'b1;
        end
        else if (clk_en)
        begin
            table_pointer <= ptr_q;
            table_byte_high <= ptr_q[0];
            ext_enabled <= ext_sync;
        end
    end
endmodule

// ==== hdl/twx_hold_mem.sv ====
// eight byte holding registers for flash programming, registered read port
module twx_hold_mem #(
    parameter int depth = 8,
    parameter int aw = 3
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [aw-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [aw-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_q [depth];

    // ==========================================
    // storage
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < depth; i++)
                mem_q[i] <= twx_pkg::hold_reset;
            rd_data <= twx_pkg::hold_reset;
        end
        else if (clk_en)
        begin
            if (wr_en)
                mem_q[wr_addr] <= wr_data;
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule

// ==== hdl/twx_sync3.sv ====
// three-stage synchroniser; change accepted when stages two and three agree
module twx_sync3 (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ==========================================
    // sampling chain
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            dout <= 1'b1;   // unprogrammed default is enabled
        end
        else if (clk_en)
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                dout <= s3_q;
        end
    end
endmodule

// ==== inc/twx_pkg.sv ====
package twx_pkg;
    // opcode patterns (upper bits compared, low bits are fields)
    localparam logic [15:0] tbl_wr_base = 16'h000c; // 0000 0000 0000 11nn
    localparam logic [13:0] tbl_wr_hi = 14'h0003;
    localparam logic [6:0] test_skip_hi = 7'h33; // 0110 011a
    localparam logic [7:0] xor_lit_hi = 8'h0a; // 0000 1010
    localparam logic [5:0] xor_reg_hi = 6'h06; // 0001 10da
    // bit 9 must be clear, else the push and move forms of the same row decode here
    localparam logic [6:0] ptr_adj_hi = 7'h74; // 1110 100s
    localparam logic [7:0] ptr_add_op = 8'he8;
    localparam logic [7:0] ptr_sub_op = 8'he9;
    localparam logic [1:0] fsr_return_sel = 2'h3;
    // table write pointer modes
    localparam logic [1:0] mode_none = 2'h0;
    localparam logic [1:0] mode_post_inc = 2'h1;
    localparam logic [1:0] mode_post_dec = 2'h2;
    localparam logic [1:0] mode_pre_inc = 2'h3;
    // widths and limits
    localparam int ptr_width = 21;
    localparam int hold_count = 8;
    localparam int hold_sel_width = 3;
    localparam logic [7:0] indexed_limit = 8'h5f;       // 95
    localparam int std_instr_count = 75;
    localparam int ext_instr_count = 8;
    localparam logic [20:0] ptr_reset = 21'h000000;
    localparam logic [7:0] hold_reset = 8'hff;          // erased flash reads ones
    localparam logic [1:0] skip_one = 2'h1;
    localparam logic [1:0] skip_two = 2'h2;

    typedef enum logic [1:0] {
        twx_idle = 2'b00,
        twx_tw2 = 2'b01,
        twx_skip = 2'b11,
        twx_ret = 2'b10
    } twx_state_type;
endpackage
